// File: inc/aux_cmd_pkg.sv
package aux_cmd_pkg;
    // ==========================================================
    // Register map, byte addresses
    // ==========================================================
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFF_CTRL = 10'h000;
    localparam logic [9:0] OFF_CMD_STAT = 10'h004;
    localparam logic [9:0] OFF_JOG = 10'h008;
    localparam logic [9:0] OFF_IRQ_STAT = 10'h00C;
    localparam logic [9:0] OFF_IRQ_MASK = 10'h010;
    localparam logic [9:0] OFF_READ_CNT = 10'h014;
    localparam logic [9:0] OFF_STATE_BASE = 10'h140;
    localparam logic [9:0] OFF_STATE_END = 10'h1C0;
    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CTRL_REQ_BIT = 0;
    localparam int CTRL_CMD_LSB = 1;
    localparam int CTRL_AXIS_LSB = 8;
    localparam int CTRL_INH_BIT = 16;
    localparam int STAT_CODE_LSB = 16;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int JOG_BITS = 3;
    localparam int JOG_CW = 0;
    localparam int JOG_CCW = 1;
    localparam int JOG_FAST = 2;
    // Words of each axis state window
    localparam logic [3:0] W_FLAGS = 4'h0;
    localparam logic [3:0] W_MCODE = 4'h1;
    localparam logic [3:0] W_POS = 4'h2;
    localparam logic [3:0] W_ERR = 4'h3;
    localparam logic [3:0] W_HOME = 4'h4;
    localparam logic [7:0] AX_WORDS = 8'h05;
    localparam int FL_MOVING = 0;
    localparam int FL_ERROR = 1;
    localparam int FL_ORIGIN = 2;
    localparam int FL_MCODE = 3;
    localparam int FL_JOG = 4;
    localparam int FL_INHIBIT = 5;
    // ==========================================================
    // Commands and error numbers
    // ==========================================================
    localparam logic [1:0] CMD_FLOAT = 2'h0;
    localparam logic [1:0] CMD_MCLEAR = 2'h1;
    localparam logic [1:0] CMD_ERR_RST = 2'h2;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_AXIS = 16'h0006;
    localparam logic [15:0] ERR_MOVING = 16'h00D4;
    localparam logic [7:0] READ_CNT_RST = AX_WORDS;
endpackage : aux_cmd_pkg

// File: core/positioning_aux_command_handler.sv
`timescale 1ns/1ps
module positioning_aux_command_handler #(
    parameter int NUM_AXES = 2
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [aux_cmd_pkg::ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    output logic irq_out,
    input wire logic module_fault_in,
    input wire logic scan_end_in,
    input wire logic [1:0] axis_moving_in,
    input wire logic [1:0] mcode_mode_in,
    input wire logic [1:0] mcode_set_in,
    input wire logic [15:0] mcode_num_in,
    input wire logic [1:0] pos_upd_in,
    input wire logic [31:0] pos_val_in,
    input wire logic [1:0] inhibit_set_in,
    output logic [1:0] jog_cw_out,
    output logic [1:0] jog_ccw_out,
    output logic [1:0] jog_fast_out,
    output logic [1:0] mcode_on_out,
    output logic [1:0] inhibit_out,
    output logic [1:0] axis_error_out,
    output logic ready_out
);
    import aux_cmd_pkg::*;

    initial begin
        if (NUM_AXES != 2) begin
            $error("Only two axes are served");
        end
    end

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic req;
        logic req_prev;
        logic [1:0] cmd;
        logic [7:0] axis;
        logic inh_cancel;
        logic done;
        logic [15:0] stat;
        logic [5:0] jog_stage;
        logic [5:0] jog_act;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [7:0] read_cnt;
        logic [1:0] mcode_on;
        logic [1:0][15:0] mcode_num;
        logic [1:0][31:0] pos;
        logic [1:0][31:0] home;
        logic [1:0][15:0] err_code;
        logic [1:0] origin;
        logic [1:0] inhibit;
        logic init;
        logic ready;
    } state_s;

    state_s s_r;
    state_s s_nxt;
    logic start;
    logic ax;
    logic ax_ok;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic [31:0] state_word(input state_s s, input logic a,
                                               input logic [3:0] w,
                                               input logic [1:0] moving);
        logic [31:0] r;
        r = 32'h0000_0000;
        if ({4'h0, w} < s.read_cnt) begin
            case (w)
                W_FLAGS: begin
                    r[FL_MOVING] = moving[a];
                    r[FL_ERROR] = (s.err_code[a] != ERR_NONE);
                    r[FL_ORIGIN] = s.origin[a];
                    r[FL_MCODE] = s.mcode_on[a];
                    r[FL_JOG] = |s.jog_act[a*JOG_BITS +: 2];
                    r[FL_INHIBIT] = s.inhibit[a];
                end
                W_MCODE: r = {16'h0000, s.mcode_num[a]};
                W_POS: r = s.pos[a];
                W_ERR: r = {16'h0000, s.err_code[a]};
                W_HOME: r = s.home[a];
                default: r = 32'h0000_0000;
            endcase
        end
        return r;
    endfunction : state_word

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic [9:0] off;
        logic [15:0] code;
        logic [31:0] w;
        off = address_in - OFF_STATE_BASE;
        code = ERR_NONE;
        w = 32'h0000_0000;
        s_nxt = s_r;
        ax = s_r.axis[0];
        ax_ok = (s_r.axis < 8'h02);
        // Only a fresh rising edge counts; a held request does nothing
        start = s_r.req & ~s_r.req_prev;
        s_nxt.req_prev = s_r.req;

        // Bus: one wait cycle, read data latched for the accepting edge
        s_nxt.ack = (read_in | write_in) & ~s_r.ack;
        if (read_in & ~s_r.ack) begin
            case (address_in)
                OFF_CTRL: begin
                    w[CTRL_REQ_BIT] = s_r.req;
                    w[CTRL_CMD_LSB +: 2] = s_r.cmd;
                    w[CTRL_AXIS_LSB +: 8] = s_r.axis;
                    w[CTRL_INH_BIT] = s_r.inh_cancel;
                end
                OFF_CMD_STAT: w = {s_r.stat, 15'h0000, s_r.done};
                OFF_JOG: w = {26'h000_0000, s_r.jog_stage};
                OFF_IRQ_STAT: w = {30'h0000_0000, s_r.irq_stat};
                OFF_IRQ_MASK: w = {30'h0000_0000, s_r.irq_mask};
                OFF_READ_CNT: w = {24'h00_0000, s_r.read_cnt};
                default: begin
                    if (address_in >= OFF_STATE_BASE && address_in < OFF_STATE_END) begin
                        w = state_word(s_r, off[6], off[5:2], axis_moving_in);
                    end
                end
            endcase
            s_nxt.rdata = w;
        end

        // Motion side events
        for (int a = 0; a < 2; a++) begin
            if (pos_upd_in[a]) begin
                s_nxt.pos[a] = pos_val_in;
            end
        end

        // Command execution
        if (start) begin
            if (!ax_ok) begin
                code = ERR_AXIS;
            end else begin
                case (s_r.cmd)
                    CMD_FLOAT: begin
                        if (axis_moving_in[ax]) begin
                            code = ERR_MOVING;
                        end else begin
                            // Home word is loaded as present position, no search
                            s_nxt.pos[ax] = s_r.home[ax];
                            s_nxt.origin[ax] = 1'b1;
                        end
                    end
                    CMD_MCLEAR: begin
                        // Axes set for immediate output keep their code
                        if (mcode_mode_in[ax]) begin
                            s_nxt.mcode_on[ax] = 1'b0;
                            s_nxt.mcode_num[ax] = 16'h0000;
                        end
                    end
                    CMD_ERR_RST: begin
                        s_nxt.err_code[ax] = ERR_NONE;
                        if (s_r.inh_cancel) begin
                            s_nxt.inhibit[ax] = 1'b0;
                        end
                    end
                    default: code = ERR_NONE;
                endcase
                if (code != ERR_NONE) begin
                    s_nxt.err_code[ax] = code;
                end
            end
            s_nxt.done = 1'b1;
            s_nxt.stat = code;
        end

        // Set wins over clear for hardware-set flags
        for (int a = 0; a < 2; a++) begin
            if (mcode_set_in[a]) begin
                s_nxt.mcode_on[a] = 1'b1;
                s_nxt.mcode_num[a] = mcode_num_in;
            end
            if (inhibit_set_in[a]) begin
                s_nxt.inhibit[a] = 1'b1;
            end
        end

        // Register writes, on the accepting edge only
        if (write_in & s_r.ack) begin
            case (address_in)
                OFF_CTRL: begin
                    w = {15'h0000, s_r.inh_cancel, s_r.axis, 5'h00, s_r.cmd, s_r.req};
                    w = be_merge(w, writedata_in, byteenable_in);
                    s_nxt.req = w[CTRL_REQ_BIT];
                    s_nxt.cmd = w[CTRL_CMD_LSB +: 2];
                    s_nxt.axis = w[CTRL_AXIS_LSB +: 8];
                    s_nxt.inh_cancel = w[CTRL_INH_BIT];
                end
                OFF_JOG: begin
                    w = be_merge({26'h000_0000, s_r.jog_stage}, writedata_in, byteenable_in);
                    s_nxt.jog_stage = w[5:0];
                end
                OFF_IRQ_STAT: begin
                    if (byteenable_in[0]) begin
                        s_nxt.irq_stat = s_r.irq_stat & ~writedata_in[1:0];
                    end
                end
                OFF_IRQ_MASK: begin
                    if (byteenable_in[0]) begin
                        s_nxt.irq_mask = writedata_in[1:0];
                    end
                end
                OFF_READ_CNT: begin
                    if (byteenable_in[0]) begin
                        s_nxt.read_cnt = writedata_in[7:0];
                    end
                end
                default: begin
                    if (address_in >= OFF_STATE_BASE && address_in < OFF_STATE_END
                        && off[5:2] == W_HOME) begin
                        s_nxt.home[off[6]] = be_merge(s_r.home[off[6]], writedata_in,
                                                      byteenable_in);
                    end
                end
            endcase
        end

        // Interrupt events set after any clear
        if (start) begin
            s_nxt.irq_stat[IRQ_DONE_BIT] = 1'b1;
            if (code != ERR_NONE) begin
                s_nxt.irq_stat[IRQ_ERR_BIT] = 1'b1;
            end
        end

        // Jog image swapped only at scan end, even mid-jog
        if (scan_end_in) begin
            s_nxt.jog_act = s_r.jog_stage;
        end

        s_nxt.init = 1'b1;
        s_nxt.ready = s_r.init & ~module_fault_in;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.read_cnt <= READ_CNT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign waitrequest_out = (read_in | write_in) & ~s_r.ack;
    assign readdata_out = s_r.rdata;
    assign irq_out = |(s_r.irq_stat & s_r.irq_mask);
    assign mcode_on_out = s_r.mcode_on;
    assign inhibit_out = s_r.inhibit;
    assign ready_out = s_r.ready;

    generate
        for (genvar a = 0; a < 2; a++) begin : g_axis
            assign jog_cw_out[a] = s_r.jog_act[a*JOG_BITS+JOG_CW];
            assign jog_ccw_out[a] = s_r.jog_act[a*JOG_BITS+JOG_CCW];
            assign jog_fast_out[a] = s_r.jog_act[a*JOG_BITS+JOG_FAST];
            assign axis_error_out[a] = (s_r.err_code[a] != ERR_NONE);
        end
    endgenerate

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_bad_axis;
        @(posedge mclk_in) disable iff (rst_in)
        start && !ax_ok |=> s_r.stat == ERR_AXIS && s_r.done;
    endproperty
    a_bad_axis: assert property (p_bad_axis) else $error("bad axis not error 6");

    property p_float_load;
        @(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_FLOAT && !axis_moving_in[ax]
        |=> s_r.pos[$past(ax)] == $past(s_r.home[ax]) && s_r.origin[$past(ax)];
    endproperty
    a_float_load: assert property (p_float_load) else $error("float origin not loaded");

    property p_float_moving;
        @(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_FLOAT && axis_moving_in[ax] && !pos_upd_in[ax]
        |=> s_r.stat == ERR_MOVING && s_r.pos[$past(ax)] == $past(s_r.pos[ax]);
    endproperty
    a_float_moving: assert property (p_float_moving) else $error("moving float accepted");

    property p_mclear;
        @(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_MCLEAR && mcode_mode_in[ax] && !mcode_set_in[ax]
        |=> !mcode_on_out[$past(ax)] && s_r.mcode_num[$past(ax)] == 16'h0000;
    endproperty
    a_mclear: assert property (p_mclear) else $error("m code not released");

    property p_done_holds;
        @(posedge mclk_in) disable iff (rst_in)
        s_r.done |=> s_r.done [*3];
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("done dropped");

    property p_level_ignored;
        @(posedge mclk_in) disable iff (rst_in)
        s_r.req && s_r.req_prev |-> !start;
    endproperty
    a_level_ignored: assert property (p_level_ignored) else $error("held request restarted");

    property p_jog_hold;
        @(posedge mclk_in) disable iff (rst_in)
        !scan_end_in |=> $stable(jog_cw_out) && $stable(jog_ccw_out) && $stable(jog_fast_out);
    endproperty
    a_jog_hold: assert property (p_jog_hold) else $error("jog changed mid scan");

    property p_jog_load;
        @(posedge mclk_in) disable iff (rst_in)
        scan_end_in |=> s_r.jog_act == $past(s_r.jog_stage);
    endproperty
    a_jog_load: assert property (p_jog_load) else $error("jog not refreshed");

    property p_err_reset;
        @(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_ERR_RST |=> !axis_error_out[$past(ax)];
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error not cleared");

    property p_err_latch;
        @(posedge mclk_in) disable iff (rst_in)
        axis_error_out[0] && !(start && ax == 1'b0 && s_r.cmd == CMD_ERR_RST && ax_ok)
        |=> axis_error_out[0];
    endproperty
    a_err_latch: assert property (p_err_latch) else $error("error lost");

    property p_ready_fault;
        @(posedge mclk_in) disable iff (rst_in)
        module_fault_in |=> !ready_out;
    endproperty
    a_ready_fault: assert property (p_ready_fault) else $error("ready with fault");

    property p_bus_answer;
        @(posedge mclk_in) disable iff (rst_in)
        (read_in || write_in) && waitrequest_out |=> !waitrequest_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_float_ok: cover property (@(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_FLOAT && !axis_moving_in[ax]);
    c_float_busy: cover property (@(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_FLOAT && axis_moving_in[ax]);
    c_mclear: cover property (@(posedge mclk_in) disable iff (rst_in)
        start && ax_ok && s_r.cmd == CMD_MCLEAR && s_r.mcode_on[ax]);
    c_jog_run: cover property (@(posedge mclk_in) disable iff (rst_in)
        scan_end_in && jog_cw_out[0] && jog_fast_out[0]);
endmodule : positioning_aux_command_handler

// File: bench/plc_scan_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host scan timing and axis side model
// ==========================================================
module plc_scan_model #(
    parameter int SCAN_LEN = 12
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [1:0] move_req_in,
    input wire logic fault_req_in,
    output logic scan_end_out,
    output logic [1:0] axis_moving_out,
    output logic module_fault_out
);
    int cnt;
    // Refresh only at the end of a whole scan, never mid-scan
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt <= 0;
            scan_end_out <= 1'b0;
        end else begin
            cnt <= (cnt == SCAN_LEN - 1) ? 0 : cnt + 1;
            scan_end_out <= (cnt == SCAN_LEN - 1);
        end
    end
    always_ff @(posedge mclk_in) begin
        axis_moving_out <= rst_in ? 2'b00 : move_req_in;
        module_fault_out <= rst_in ? 1'b0 : fault_req_in;
    end
endmodule : plc_scan_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import aux_cmd_pkg::*;
    logic mclk_in, rst_in, read_in, write_in, module_fault_in, scan_end_in;
    logic [9:0] address_in;
    logic [31:0] writedata_in, readdata_out, pos_val_in;
    logic [3:0] byteenable_in;
    logic waitrequest_out, irq_out, ready_out, fault_req;
    logic [1:0] axis_moving_in, mcode_mode_in, mcode_set_in, pos_upd_in, inhibit_set_in;
    logic [1:0] jog_cw_out, jog_ccw_out, jog_fast_out, mcode_on_out, inhibit_out;
    logic [1:0] axis_error_out, move_req;
    logic [15:0] mcode_num_in;
    int err_count = 0;
    int compares = 0;
    positioning_aux_command_handler #(.NUM_AXES(2)) positioning_aux_command_handler_i (
        .mclk_in(mclk_in), .rst_in(rst_in), .address_in(address_in), .read_in(read_in),
        .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .irq_out(irq_out),
        .module_fault_in(module_fault_in), .scan_end_in(scan_end_in),
        .axis_moving_in(axis_moving_in), .mcode_mode_in(mcode_mode_in),
        .mcode_set_in(mcode_set_in), .mcode_num_in(mcode_num_in), .pos_upd_in(pos_upd_in),
        .pos_val_in(pos_val_in), .inhibit_set_in(inhibit_set_in), .jog_cw_out(jog_cw_out),
        .jog_ccw_out(jog_ccw_out), .jog_fast_out(jog_fast_out), .mcode_on_out(mcode_on_out),
        .inhibit_out(inhibit_out), .axis_error_out(axis_error_out), .ready_out(ready_out));
    plc_scan_model #(.SCAN_LEN(12)) plc_scan_model_i (
        .mclk_in(mclk_in), .rst_in(rst_in), .move_req_in(move_req), .fault_req_in(fault_req),
        .scan_end_out(scan_end_in), .axis_moving_out(axis_moving_in),
        .module_fault_out(module_fault_in));
    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        summarize();
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic summarize();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr_en, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= wr_en;
        read_in <= ~wr_en;
        @(negedge mclk_in);
        while (waitrequest_out !== 1'b0 && n < 16) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 16) begin
            err_count++;
            summarize();
        end
        // Accepting edge: read data still stands here, then release
        @(posedge mclk_in);
        q = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
    endtask : bus
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check_val(q, exp);
    endtask : rd
    function automatic logic [31:0] ctrl_word(logic [1:0] c, logic [7:0] ax, logic inh);
        return {15'h0, inh, ax, 5'h00, c, 1'b1};
    endfunction : ctrl_word
    // Request goes low first so the next write is a fresh rising edge
    task automatic cmd(input logic [1:0] c, input logic [7:0] ax, input logic inh);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, ctrl_word(c, ax, inh));
        repeat (2) @(negedge mclk_in);
    endtask : cmd
    task automatic pulses(input logic [1:0] ms, input logic [1:0] pu, input logic [1:0] is);
        @(posedge mclk_in);
        mcode_set_in <= ms;
        pos_upd_in <= pu;
        inhibit_set_in <= is;
        @(posedge mclk_in);
        mcode_set_in <= 2'b00;
        pos_upd_in <= 2'b00;
        inhibit_set_in <= 2'b00;
        @(negedge mclk_in);
    endtask : pulses
    task automatic wait_scan();
        int n;
        n = 0;
        while (scan_end_in !== 1'b1 && n < 40) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            summarize();
        end
        @(negedge mclk_in);
    endtask : wait_scan
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rst_in = 1'b1;
        {read_in, write_in, fault_req} = 3'b000;
        address_in = 10'h000;
        writedata_in = 32'h0;
        byteenable_in = 4'hF;
        {move_req, mcode_set_in, pos_upd_in, inhibit_set_in} = 8'h00;
        mcode_mode_in = 2'b01;
        mcode_num_in = 16'h0007;
        pos_val_in = 32'h0000_00AA;
        repeat (4) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(negedge mclk_in);
        check_val(ready_out, 1'b0);
        repeat (2) @(negedge mclk_in);
        check_val(ready_out, 1'b1);
        rd(OFF_READ_CNT, 32'h5);
        rd(10'h020, 32'h0);
        wr(OFF_IRQ_MASK, 32'h3);
        wr(10'h150, 32'h1234_5678);
        check_val(axis_error_out, 2'b00);
        cmd(CMD_FLOAT, 8'h00, 1'b0);
        rd(OFF_CMD_STAT, 32'h1);
        rd(10'h148, 32'h1234_5678);
        rd(10'h140, 32'h4);
        check_val(irq_out, 1'b1);
        rd(OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        @(negedge mclk_in);
        check_val(irq_out, 1'b0);
        // Request left high must not start the command again
        pulses(2'b00, 2'b01, 2'b00);
        wr(OFF_CTRL, ctrl_word(CMD_FLOAT, 8'h00, 1'b0));
        repeat (2) @(negedge mclk_in);
        rd(10'h148, 32'h0000_00AA);
        move_req <= 2'b10;
        wr(10'h190, 32'h0000_0055);
        cmd(CMD_FLOAT, 8'h01, 1'b0);
        rd(OFF_CMD_STAT, 32'h00D4_0001);
        rd(10'h188, 32'h0);
        rd(10'h18C, 32'h0000_00D4);
        check_val(axis_error_out, 2'b10);
        rd(OFF_IRQ_STAT, 32'h3);
        cmd(CMD_FLOAT, 8'h02, 1'b0);
        rd(OFF_CMD_STAT, 32'h0006_0001);
        check_val(axis_error_out, 2'b10);
        wr(OFF_IRQ_MASK, 32'h0);
        @(negedge mclk_in);
        check_val(irq_out, 1'b0);
        wr(OFF_IRQ_MASK, 32'h3);
        @(negedge mclk_in);
        check_val(irq_out, 1'b1);
        wr(OFF_IRQ_STAT, 32'h3);
        @(negedge mclk_in);
        check_val(irq_out, 1'b0);
        move_req <= 2'b00;
        pulses(2'b00, 2'b00, 2'b10);
        check_val(inhibit_out, 2'b10);
        cmd(CMD_ERR_RST, 8'h01, 1'b0);
        check_val(axis_error_out, 2'b00);
        check_val(inhibit_out, 2'b10);
        cmd(CMD_ERR_RST, 8'h01, 1'b1);
        check_val(inhibit_out, 2'b00);
        rd(10'h18C, 32'h0);
        cmd(CMD_FLOAT, 8'h01, 1'b0);
        rd(10'h188, 32'h0000_0055);
        pulses(2'b11, 2'b00, 2'b00);
        check_val(mcode_on_out, 2'b11);
        cmd(CMD_MCLEAR, 8'h00, 1'b0);
        check_val(mcode_on_out, 2'b10);
        rd(10'h144, 32'h0);
        cmd(CMD_MCLEAR, 8'h01, 1'b0);
        check_val(mcode_on_out, 2'b10);
        rd(10'h184, 32'h0000_0007);
        wr(OFF_JOG, 32'h0000_0005);
        @(negedge mclk_in);
        check_val(jog_cw_out, 2'b00);
        wait_scan();
        check_val({jog_cw_out, jog_ccw_out, jog_fast_out}, 6'b01_00_01);
        wr(OFF_JOG, 32'h0000_0006);
        wait_scan();
        check_val({jog_cw_out, jog_ccw_out, jog_fast_out}, 6'b00_01_01);
        wr(OFF_READ_CNT, 32'h2);
        rd(10'h184, 32'h0000_0007);
        rd(10'h188, 32'h0);
        fault_req <= 1'b1;
        repeat (3) @(negedge mclk_in);
        check_val(ready_out, 1'b0);
        summarize();
    end
endmodule : testbench
